/* core/cmpctl_regs.vh */
// Register offsets, field positions, reset values and timing counts of the comparator control block
`ifndef CMPCTL_REGS_VH
`define CMPCTL_REGS_VH

// Byte addresses of the word registers
`define CMPCTL_OFS_CTRL1 8'h00
`define CMPCTL_OFS_CTRL2 8'h04
`define CMPCTL_OFS_STAT 8'h08
`define CMPCTL_OFS_MASK 8'h0C
`define CMPCTL_OFS_GLOB 8'h10

// Fields of each comparator control register
`define CMPCTL_B_FLAG 0
`define CMPCTL_B_RESULT 1
`define CMPCTL_B_PINEN 2
`define CMPCTL_B_NEGSEL 3
`define CMPCTL_B_ON 5

// Status register: flags in [1:0], settled bits in [3:2]
`define CMPCTL_B_SETTLED 2

// Reset value of a control register (all writable fields cleared)
`define CMPCTL_CTRL_RST 8'h00

// Settling time of an enabled comparator
`define CMPCTL_CLK_MHZ 40
`define CMPCTL_SETTLE_US 10
`define CMPCTL_SETTLE_CYC (`CMPCTL_SETTLE_US * `CMPCTL_CLK_MHZ)

`endif

/* core/cmpctl_top.v */
// Control and status logic of two analog comparators, reached over AHB-Lite
//
// Function
// - Output change sets the interrupt flag
// - Enabled set flag raises interrupt request
// - Read-only result synchronised to CPU clock
// - Enable bit; output valid after 10 us
// - Negative select: 0 pin, 1 internal reference
// - Pin driven when pin enable and on
// - Pin path bypasses the synchroniser
// - Disabled comparator reads high, may set flag
// - Request needs comparator and global gates
// - Total power-down forces comparators off
//
// Local design decisions: the register addresses and the AHB-Lite register port.
`include "cmpctl_regs.vh"

module cmpctl_top
(
	input wire clk,
	input wire rst_n,
	// AHB-Lite slave
	input wire hsel,
	input wire [7:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	// Analog comparator cores
	input wire [1:0] cmp_raw,
	output reg [1:0] comparator_on,
	output reg [1:0] negative_input_select,
	// Output pins, driven straight from the analog result
	output wire [1:0] result_pin,
	// Registered together with the analog enable, so it never leads it
	output reg [1:0] result_pin_oe,
	// Power state and interrupt
	input wire total_power_down,
	output reg irq
);

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	reg rst_s1_q;
	reg rst_s2_q;
	wire rst_int_n;

	// Asynchronous assert, synchronous release
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end
		else
		begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end
	assign rst_int_n = rst_s2_q;

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	reg [1:0] on_q;
	reg [1:0] negsel_q;
	reg [1:0] pinen_q;
	reg [1:0] flag_q;
	reg [1:0] flag_d;
	reg [1:0] mask_q;
	reg glob_q;
	reg [1:0] sync1_q;
	reg [1:0] sync2_q;
	reg [1:0] result_q;
	reg [1:0] result_d;
	reg [1:0] settled_q;
	reg [8:0] settle_cnt_q [0:1];
	reg pend_q;
	reg pend_wr_q;
	reg [7:0] pend_addr_q;
	wire accept;
	wire wr_now;
	wire wr_stat;
	wire wr_ctrl1;
	wire wr_ctrl2;
	integer si;

	// Last count of the start-up timer, kept wide so the compare is sized on purpose
	localparam [31:0] SETTLE_LAST_W = `CMPCTL_SETTLE_CYC - 1;

	// Control register image of one comparator; bits 7:6 and 4 read zero
	function [31:0] ctrl_image;
		input on;
		input negsel;
		input pinen;
		input result;
		input flag;
		begin
			ctrl_image = 32'h0000_0000;
			ctrl_image[`CMPCTL_B_ON] = on;
			ctrl_image[`CMPCTL_B_NEGSEL] = negsel;
			ctrl_image[`CMPCTL_B_PINEN] = pinen;
			ctrl_image[`CMPCTL_B_RESULT] = result;
			ctrl_image[`CMPCTL_B_FLAG] = flag;
		end
	endfunction

	// Write strobe of one register in its data phase
	function wr_hit;
		input pend;
		input wr;
		input [7:0] addr;
		input [7:0] target;
		begin
			wr_hit = pend & wr & (addr == target);
		end
	endfunction

	// ----------------------------------------
	// Bus handshake: one wait cycle per transfer
	// ----------------------------------------
	assign accept = hsel & htrans[1] & hready;
	assign wr_now = pend_q & pend_wr_q;

	// ----------------------------------------
	// Register write strobes
	// ----------------------------------------
	// Decoded for the flag logic; the field logic decodes pend_addr_q in its own case statement
	assign wr_stat = wr_hit(pend_q, pend_wr_q, pend_addr_q, `CMPCTL_OFS_STAT);
	assign wr_ctrl1 = wr_hit(pend_q, pend_wr_q, pend_addr_q, `CMPCTL_OFS_CTRL1);
	assign wr_ctrl2 = wr_hit(pend_q, pend_wr_q, pend_addr_q, `CMPCTL_OFS_CTRL2);

	// Address phase is latched; data phase completes a cycle later
	always @(posedge clk or negedge rst_int_n)
	begin
		if (!rst_int_n)
		begin
			pend_q <= 1'b0;
			pend_wr_q <= 1'b0;
			pend_addr_q <= 8'h00;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h0000_0000;
		end
		else
		begin
			hresp <= 1'b0;
			if (pend_q)
			begin
				pend_q <= 1'b0;
				hreadyout <= 1'b1;
				if (!pend_wr_q)
				begin
					case (pend_addr_q)
						`CMPCTL_OFS_CTRL1: hrdata <= ctrl_image(on_q[0], negsel_q[0], pinen_q[0], result_q[0], flag_q[0]);
						`CMPCTL_OFS_CTRL2: hrdata <= ctrl_image(on_q[1], negsel_q[1], pinen_q[1], result_q[1], flag_q[1]);
						`CMPCTL_OFS_STAT: hrdata <= {28'h000_0000, settled_q, flag_q};
						`CMPCTL_OFS_MASK: hrdata <= {30'h0000_0000, mask_q};
						`CMPCTL_OFS_GLOB: hrdata <= {31'h0000_0000, glob_q};
						default: hrdata <= 32'h0000_0000;
					endcase
				end
			end
			else if (accept)
			begin
				pend_q <= 1'b1;
				pend_wr_q <= hwrite;
				pend_addr_q <= {haddr[7:2], 2'b00};
				hreadyout <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Writable control fields
	// ----------------------------------------
	always @(posedge clk or negedge rst_int_n)
	begin
		if (!rst_int_n)
		begin
			on_q <= 2'b00;
			negsel_q <= 2'b00;
			pinen_q <= 2'b00;
			mask_q <= 2'b00;
			glob_q <= 1'b0;
		end
		else if (wr_now)
		begin
			case (pend_addr_q)
				`CMPCTL_OFS_CTRL1:
				begin
					on_q[0] <= hwdata[`CMPCTL_B_ON];
					negsel_q[0] <= hwdata[`CMPCTL_B_NEGSEL];
					pinen_q[0] <= hwdata[`CMPCTL_B_PINEN];
				end
				`CMPCTL_OFS_CTRL2:
				begin
					on_q[1] <= hwdata[`CMPCTL_B_ON];
					negsel_q[1] <= hwdata[`CMPCTL_B_NEGSEL];
					pinen_q[1] <= hwdata[`CMPCTL_B_PINEN];
				end
				`CMPCTL_OFS_MASK: mask_q <= hwdata[1:0];
				`CMPCTL_OFS_GLOB: glob_q <= hwdata[0];
				default: glob_q <= glob_q;
			endcase
		end
	end

	// ----------------------------------------
	// Analog controls and settling timers
	// ----------------------------------------
	// Total power-down overrides the enable bit without altering it
	always @(posedge clk or negedge rst_int_n)
	begin
		if (!rst_int_n)
		begin
			comparator_on <= 2'b00;
			negative_input_select <= 2'b00;
			result_pin_oe <= 2'b00;
		end
		else
		begin
			comparator_on <= on_q & {2{~total_power_down}};
			negative_input_select <= negsel_q;
			// Same term as the enable, so the pin is released with the core
			result_pin_oe <= pinen_q & on_q & {2{~total_power_down}};
		end
	end

	// Counts the start-up time after each enable; settled bit is status only
	// One process for both timers, so each status bit has a single driver
	always @(posedge clk or negedge rst_int_n)
	begin
		if (!rst_int_n)
		begin
			settle_cnt_q[0] <= 9'h000;
			settle_cnt_q[1] <= 9'h000;
			settled_q <= 2'b00;
		end
		else
		begin
			for (si = 0; si < 2; si = si + 1)
			begin
				if (!comparator_on[si])
				begin
					settle_cnt_q[si] <= 9'h000;
					settled_q[si] <= 1'b0;
				end
				else if ({23'h000000, settle_cnt_q[si]} == SETTLE_LAST_W)
					settled_q[si] <= 1'b1;
				else
					settle_cnt_q[si] <= settle_cnt_q[si] + 9'h001;
			end
		end
	end

	// ----------------------------------------
	// Result synchroniser and change detection
	// ----------------------------------------
	// Disabled comparator reads high, so disabling from low counts as a change
	always @*
	begin
		result_d = sync2_q | ~comparator_on;
		flag_d = flag_q | (result_d ^ result_q);
		// A change in the clearing cycle still sets the flag: set wins
		if (wr_stat)
			flag_d = (flag_q & ~hwdata[1:0]) | (result_d ^ result_q);
		else if (wr_ctrl1 && !hwdata[`CMPCTL_B_FLAG])
			flag_d[0] = result_d[0] ^ result_q[0];
		else if (wr_ctrl2 && !hwdata[`CMPCTL_B_FLAG])
			flag_d[1] = result_d[1] ^ result_q[1];
	end

	// Two-stage synchroniser; first stage feeds only the second
	always @(posedge clk or negedge rst_int_n)
	begin
		if (!rst_int_n)
		begin
			sync1_q <= 2'b11;
			sync2_q <= 2'b11;
			result_q <= 2'b11;
			flag_q <= 2'b00;
			irq <= 1'b0;
		end
		else
		begin
			sync1_q <= cmp_raw;
			sync2_q <= sync1_q;
			result_q <= result_d;
			flag_q <= flag_d;
			irq <= glob_q & |(flag_q & mask_q);
		end
	end

	// ----------------------------------------
	// Output pin path
	// ----------------------------------------
	// Deliberately combinational so pin edges do not wait for the CPU clock;
	// the only output that does not come from a flop, by necessity
	assign result_pin = cmp_raw;

endmodule

/* dv/cmpctl_chk.sv */
// Port assertions of the comparator control block
module cmpctl_chk
(
	input wire clk,
	input wire rst_n,
	input wire hsel,
	input wire [1:0] htrans,
	input wire hready,
	input wire hreadyout,
	input wire hresp,
	input wire [1:0] cmp_raw,
	input wire [1:0] comparator_on,
	input wire [1:0] negative_input_select,
	input wire [1:0] result_pin,
	input wire [1:0] result_pin_oe,
	input wire total_power_down,
	input wire irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Data phase of exactly one wait cycle
	sequence s_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	// Only a finished access or the power state may move settings
	sequence s_cause;
		!$past(hreadyout) || !$past(hreadyout, 2) || $past(total_power_down, 2);
	endsequence
	a_pin_async: assert property (result_pin == cmp_raw) else $error("pin not raw");
	a_oe_needs_on: assert property ((result_pin_oe & ~comparator_on) == 2'h0) else $error("pin off");
	a_pd_off: assert property (total_power_down |=> comparator_on == 2'h0) else $error("pd on");
	a_one_wait: assert property (hsel && htrans[1] && hready |=> s_wait) else $error("wait");
	a_okay_resp: assert property (hresp == 1'b0) else $error("resp");
	a_on_cause: assert property ((comparator_on & ~$past(comparator_on)) != 2'h0 |-> s_cause) else $error("on");
	a_sel_cause: assert property ($changed(negative_input_select) |-> s_cause) else $error("sel");
	a_irq_held: assert property ($fell(irq) |-> s_cause) else $error("irq fell");
endmodule

/* dv/cmpctl_far.sv */
// Behavioural analog comparator pair
module cmpctl_far
(
	input wire clk,
	input wire [1:0] comparator_on,
	input wire [1:0] negative_input_select,
	input wire [1:0] above_pin,
	input wire [1:0] above_int,
	output logic [1:0] cmp_raw
);
	timeunit 1ns;
	timeprecision 1ps;
	logic wob = 1'b0;
	// An unpowered core has no defined result, so it wobbles
	always @(posedge clk)
		wob <= ~wob;
	// Select 0 compares with the pin, 1 with the internal reference
	always_comb
	begin
		for (int i = 0; i < 2; i++)
			cmp_raw[i] = comparator_on[i] ? (negative_input_select[i] ? above_int[i] : above_pin[i]) : wob;
	end
endmodule

/* dv/testbench.sv */
// Self-checking bench of the comparator control block
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, tpd = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0, ab_pin = 2'h3, ab_int = 2'h3;
	logic [31:0] hwdata = 32'h0, r;
	wire [31:0] hrdata;
	wire hreadyout, hresp, irq;
	wire [1:0] raw, con, nsel, pin, oe;
	int fails = 0, check_count = 0;
	// 40 MHz clock
	initial
	begin
		forever #12.5 clk = ~clk;
	end
	cmpctl_top uut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.cmp_raw(raw), .comparator_on(con), .negative_input_select(nsel), .result_pin(pin), .result_pin_oe(oe),
		.total_power_down(tpd), .irq(irq));
	cmpctl_far far (.clk(clk), .comparator_on(con), .negative_input_select(nsel), .above_pin(ab_pin),
		.above_int(ab_int), .cmp_raw(raw));
	// Counts, verdict and end of run
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		check_count++;
		if (s !== e)
		begin
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
			fails++;
		end
	endtask
	// One single AHB-Lite word transfer; the wait is bounded
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1 && ++n < 50);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1 && ++n < 50);
		r = hrdata;
		if (n >= 50)
		begin
			fails++;
			tally_and_finish;
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
		bus(1'b0, a, 32'h0);
		chk(nm, e, r & m);
	endtask
	task automatic t_reset;
		rd(8'h00, 32'hFFFFFFFF, 32'h2, "ctrl1");
		rd(8'h14, 32'hFFFFFFFF, 32'h0, "unmapped");
	endtask
	// Settled bit must not show early; flags cleared after start-up
	task automatic t_enable;
		bus(1'b1, 8'h00, 32'h24);
		#1;
		chk("pin en", 32'h1, 32'(oe[0]));
		repeat (390) @(posedge clk);
		rd(8'h08, 32'h4, 32'h0, "early");
		repeat (10) @(posedge clk);
		rd(8'h08, 32'h4, 32'h4, "settled");
		bus(1'b1, 8'h08, 32'h3);
	endtask
	task automatic t_irq;
		bus(1'b1, 8'h0C, 32'h1);
		bus(1'b1, 8'h10, 32'h1);
		ab_pin <= 2'h2;
		repeat (6) @(posedge clk);
		chk("irq", 32'h1, 32'(irq));
		rd(8'h00, 32'hFF, 32'h25, "flag");
		bus(1'b1, 8'h0C, 32'h0);
		@(posedge clk);
		chk("masked", 32'h0, 32'(irq));
		bus(1'b1, 8'h0C, 32'h1);
		bus(1'b1, 8'h10, 32'h0);
		@(posedge clk);
		chk("global", 32'h0, 32'(irq));
		bus(1'b1, 8'h10, 32'h1);
		@(posedge clk);
		chk("kept", 32'h1, 32'(irq));
		bus(1'b1, 8'h00, 32'h24);
		@(posedge clk);
		chk("cleared", 32'h0, 32'(irq));
	endtask
	// Internal reference, then disabling while the result is low
	task automatic t_select;
		bus(1'b1, 8'h00, 32'h2C);
		repeat (6) @(posedge clk);
		chk("nsel", 32'h1, 32'(nsel));
		rd(8'h00, 32'hFE, 32'h2E, "int ref");
		ab_int <= 2'h2;
		repeat (6) @(posedge clk);
		bus(1'b1, 8'h08, 32'h3);
		bus(1'b1, 8'h00, 32'h0);
		repeat (4) @(posedge clk);
		chk("pin off", 32'h0, 32'(oe));
		rd(8'h00, 32'hFF, 32'h3, "off flag");
	endtask
	task automatic t_second;
		bus(1'b1, 8'h04, 32'hFF);
		rd(8'h04, 32'hFC, 32'h2C, "ctrl2");
		chk("pin2", 32'h2, 32'(oe));
		tpd <= 1'b1;
		repeat (2) @(posedge clk);
		chk("pd", 32'h0, 32'(con));
		chk("pd pin", 32'h0, 32'(oe));
		rd(8'h04, 32'hFE, 32'h2E, "pd high");
		tpd <= 1'b0;
	endtask
	initial
	begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset;
		t_enable;
		t_irq;
		t_select;
		t_second;
		tally_and_finish;
	end
endmodule
bind cmpctl_top cmpctl_chk chk_i (.clk(clk), .rst_n(rst_n), .hsel(hsel), .htrans(htrans), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .cmp_raw(cmp_raw), .comparator_on(comparator_on),
	.negative_input_select(negative_input_select), .result_pin(result_pin), .result_pin_oe(result_pin_oe),
	.total_power_down(total_power_down), .irq(irq));
